// *** hdl/swa_host.sv ***
// front end controller for single wire line activation
// Functional notes
// R1 - line stays low while card supply off
// R2 - low to high line edge activates card
// R3 - shutdown: drop line, then drop supply
// R4 - card resumes within 700 us after activation
// R5 - no resume seen: deactivate the line
// R6 - card drops current within 100 ms unactivated
// R7 - card sends first sync, then waits
// R8 - good sync, full power: send repeat 0
// R9 - good sync, low power: activation done
// R10 - bad or missing frame: send repeat 1
// R11 - card repeats or answers ready per bit
// R12 - card ignores corrupted front end frames
// R13 - sync after repeat or ready ends activation
// R14 - at most three repeat requests per attempt
// R15 - out of order frame counts as corrupted
// R16 - failed activation deactivates the line
// R17 - initial syncs carry activation information
// R18 - subsequent frames omit activation information
// R19 - subsequent: first good sync ends activation
// R20 - raise line 1000 us after supply on
// R21 - card answers power frame within 2000 us
// R22 - card resumes within 500 us when subsequent
// R23 - sample slave current only while line high
// R24 - response timeout drives repeat or failure
`timescale 1ns/1ps
`default_nettype none
`include "swa_defines.svh"
module swa_host #(
  parameter int LINE_RAISE_CYC = `SWA_T_LINE_RAISE_US * `SWA_CLK_MHZ,
  parameter int RES_SUPPLY_CYC = `SWA_T_RES_SUPPLY_US * `SWA_CLK_MHZ,
  parameter int RES_DEACT_CYC = `SWA_T_RES_DEACT_US * `SWA_CLK_MHZ,
  parameter int REPLY_CYC = `SWA_T_FRAME_REPLY_US * `SWA_CLK_MHZ
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic supply_en, // card supply on
  output logic master_voltage_signal, // line level, high = activated
  input wire logic slave_current_signal, // card current, asynchronous
  input wire swa_pkg::swa_rx_s rx_frame, // frames decoded by framer
  output swa_pkg::swa_tx_s tx_frame, // power mode frame request
  input wire logic tx_ready, // framer takes tx_frame
  output logic link_activated // link in activated state
);
  swa_pkg::swa_state_e state_q, state_d;
  logic [`SWA_CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] rep_q, rep_d;
  logic supply_q, supply_d, line_q, line_d, link_q, link_d;
  logic first_sync_q, first_sync_d, last_fr_q, last_fr_d;
  logic subseq_q, subseq_d, settled_q, settled_d;
  logic ok_q, ok_d, fail_q, fail_d, lowpwr_q, lowpwr_d;
  swa_pkg::swa_tx_s tx_q, tx_d;
  logic sc_s1_q, sc_s2_q, ln_s1_q, ln_s2_q;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic wr_fire, cmd_start, cmd_stop, need_rep, hit;

  // cycle count of a time, truncated to the counter width
  function automatic logic [`SWA_CNT_W-1:0] cyc(input int n);
    cyc = `SWA_CNT_W'(n);
  endfunction

  // two flops on the card current input, line level delayed alike
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sc_s1_q <= 1'b0;
      sc_s2_q <= 1'b0;
      ln_s1_q <= 1'b0;
      ln_s2_q <= 1'b0;
    end else begin
      sc_s1_q <= slave_current_signal;
      sc_s2_q <= sc_s1_q;
      ln_s1_q <= line_q;
      ln_s2_q <= ln_s1_q;
    end
  end

  // apb slave: ready in second access cycle, write then takes effect
  always_comb begin
    hit = (paddr == `SWA_OFF_CTRL) || (paddr == `SWA_OFF_STATUS);
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !hit;
    prdata_d = 32'h0;
    if (pready_d && !pwrite && paddr == `SWA_OFF_CTRL) begin
      prdata_d = {29'h0, lowpwr_q, 2'h0};
    end else if (pready_d && !pwrite && paddr == `SWA_OFF_STATUS) begin
      prdata_d = {16'h0, rep_q, subseq_q, fail_q, ok_q, link_q, line_q,
                  supply_q, state_q};
    end
    wr_fire = psel && penable && pready_q && pwrite
              && paddr == `SWA_OFF_CTRL;
    cmd_start = wr_fire && pwdata[`SWA_CTRL_START];
    cmd_stop = wr_fire && pwdata[`SWA_CTRL_STOP];
    lowpwr_d = wr_fire ? pwdata[`SWA_CTRL_LOWPWR] : lowpwr_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      lowpwr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      lowpwr_q <= lowpwr_d;
    end
  end

  // activation sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - `SWA_CNT_W'(1);
    rep_d = rep_q;
    supply_d = supply_q;
    line_d = line_q;
    link_d = link_q;
    first_sync_d = first_sync_q;
    last_fr_d = last_fr_q;
    subseq_d = subseq_q;
    settled_d = settled_q;
    ok_d = ok_q;
    fail_d = fail_q;
    tx_d = tx_q;
    need_rep = 1'b0;
    if (tx_q.valid && tx_ready) begin
      tx_d.valid = 1'b0;
      cnt_d = cyc(REPLY_CYC);
    end
    case (state_q)
      swa_pkg::SWA_IDLE, swa_pkg::SWA_SUCCESS, swa_pkg::SWA_FAIL: begin
        if (cmd_stop) begin
          // R3 line down first
          line_d = 1'b0;
          link_d = 1'b0;
          state_d = swa_pkg::SWA_SHUTDOWN;
        end else if (cmd_start && !line_q) begin
          ok_d = 1'b0;
          fail_d = 1'b0;
          rep_d = 2'h0;
          first_sync_d = 1'b0;
          last_fr_d = 1'b0;
          supply_d = 1'b1;
          if (supply_q && settled_q) begin
            // R2 raise line to activate card
            line_d = 1'b1;
            cnt_d = subseq_q ? cyc(RES_DEACT_CYC) : cyc(RES_SUPPLY_CYC);
            state_d = swa_pkg::SWA_RESUME_WAIT;
          end else begin
            // R20 supply settles before line rises
            cnt_d = cyc(LINE_RAISE_CYC);
            state_d = swa_pkg::SWA_PWR_WAIT;
          end
        end
      end
      swa_pkg::SWA_PWR_WAIT: begin
        if (cnt_q == '0) begin
          settled_d = 1'b1;
          line_d = 1'b1;
          cnt_d = cyc(RES_SUPPLY_CYC);
          state_d = swa_pkg::SWA_RESUME_WAIT;
        end
      end
      swa_pkg::SWA_RESUME_WAIT: begin
        // R23 current counts only with the line high
        if (sc_s2_q && line_q && ln_s2_q) begin
          link_d = 1'b1;
          cnt_d = cyc(REPLY_CYC);
          state_d = swa_pkg::SWA_SYNC_WAIT;
        end else if (cnt_q == '0) begin
          // R5 no resume, give up the line
          state_d = swa_pkg::SWA_FAIL;
        end
      end
      swa_pkg::SWA_SYNC_WAIT: begin
        if (rx_frame.valid && rx_frame.kind == swa_pkg::SWA_RX_SYNC) begin
          first_sync_d = 1'b1;
          if (subseq_q || lowpwr_q) begin
            // R9 R19 done on first good sync
            state_d = swa_pkg::SWA_SUCCESS;
          end else begin
            // R8 full power answer
            tx_d = '{valid: 1'b1, repeat_request_bit: 1'b0,
                     full_power: 1'b1};
            last_fr_d = 1'b0;
            state_d = swa_pkg::SWA_RESP_WAIT;
          end
        end else if (rx_frame.valid || cnt_q == '0) begin
          // R15 R24 wrong, corrupt or missing frame
          need_rep = 1'b1;
        end
      end
      swa_pkg::SWA_RESP_WAIT: begin
        if (tx_q.valid) begin
          state_d = state_q;
        end else if (rx_frame.valid && rx_frame.kind == swa_pkg::SWA_RX_SYNC
                     && last_fr_q) begin
          // R13 sync after repeat request
          state_d = swa_pkg::SWA_SUCCESS;
        end else if (rx_frame.valid
                     && rx_frame.kind == swa_pkg::SWA_RX_READY
                     && first_sync_q) begin
          // R13 ready after good first sync
          state_d = swa_pkg::SWA_SUCCESS;
        end else if (rx_frame.valid || cnt_q == '0) begin
          // R15 R24 out of order or no answer
          need_rep = 1'b1;
        end
      end
      swa_pkg::SWA_SHUTDOWN: begin
        // R3 supply off one cycle after line
        supply_d = 1'b0;
        settled_d = 1'b0;
        subseq_d = 1'b0;
        state_d = swa_pkg::SWA_IDLE;
      end
      default: begin
        state_d = swa_pkg::SWA_IDLE;
      end
    endcase
    if (need_rep) begin
      if (rep_q == `SWA_MAX_REPEATS) begin
        // R14 limit reached, R16 give up
        state_d = swa_pkg::SWA_FAIL;
      end else begin
        // R10 repeat request with current power mode
        tx_d = '{valid: 1'b1, repeat_request_bit: 1'b1,
                 full_power: !lowpwr_q};
        last_fr_d = 1'b1;
        rep_d = rep_q + 2'h1;
        state_d = swa_pkg::SWA_RESP_WAIT;
      end
    end
    if (state_d == swa_pkg::SWA_FAIL && state_q != swa_pkg::SWA_FAIL) begin
      // R16 failure drops the line
      line_d = 1'b0;
      link_d = 1'b0;
      tx_d.valid = 1'b0;
      fail_d = 1'b1;
    end
    if (state_d == swa_pkg::SWA_SUCCESS
        && state_q != swa_pkg::SWA_SUCCESS) begin
      ok_d = 1'b1;
      subseq_d = 1'b1;
    end
    // R1 line never high without supply
    if (!supply_d) begin
      line_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= swa_pkg::SWA_IDLE;
      cnt_q <= '0;
      rep_q <= 2'h0;
      supply_q <= 1'b0;
      line_q <= 1'b0;
      link_q <= 1'b0;
      first_sync_q <= 1'b0;
      last_fr_q <= 1'b0;
      subseq_q <= 1'b0;
      settled_q <= 1'b0;
      ok_q <= 1'b0;
      fail_q <= 1'b0;
      tx_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rep_q <= rep_d;
      supply_q <= supply_d;
      line_q <= line_d;
      link_q <= link_d;
      first_sync_q <= first_sync_d;
      last_fr_q <= last_fr_d;
      subseq_q <= subseq_d;
      settled_q <= settled_d;
      ok_q <= ok_d;
      fail_q <= fail_d;
      tx_q <= tx_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign supply_en = supply_q;
  assign master_voltage_signal = line_q;
  assign tx_frame = tx_q;
  assign link_activated = link_q;

  // cycles since supply came on, for the raise delay check
  logic [`SWA_CNT_W-1:0] age_q;
  always_ff @(posedge sys_clk) begin
    if (reset || !supply_q) begin
      age_q <= '0;
    end else if (age_q != '1) begin
      age_q <= age_q + `SWA_CNT_W'(1);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_line_needs_supply: assert property ( // R1
    line_q |-> supply_q) else $error("line high without supply");
  chk_raise_after_delay: assert property ( // R20
    $rose(line_q) |-> age_q >= cyc(LINE_RAISE_CYC))
    else $error("line raised too soon after supply");
  chk_supply_after_line: assert property ( // R3
    $fell(supply_q) |-> !$past(line_q) && !line_q)
    else $error("supply removed before line");
  chk_fail_drops_line: assert property ( // R16
    state_q == swa_pkg::SWA_FAIL |-> !line_q && !tx_q.valid)
    else $error("failed attempt keeps line");
  chk_resume_timeout: assert property ( // R5
    state_q == swa_pkg::SWA_RESUME_WAIT && cnt_q == '0 && !sc_s2_q
    |=> state_q == swa_pkg::SWA_FAIL) else $error("no resume not failed");
  chk_repeat_limit: assert property ( // R14
    $rose(tx_q.valid) && tx_q.repeat_request_bit |-> rep_q != 2'h0
    ##0 $past(rep_q) != `SWA_MAX_REPEATS)
    else $error("too many repeat requests");
  chk_full_power_reply: assert property ( // R8
    state_q == swa_pkg::SWA_SYNC_WAIT && rx_frame.valid
    && rx_frame.kind == swa_pkg::SWA_RX_SYNC && !subseq_q && !lowpwr_q
    |=> tx_q.valid && !tx_q.repeat_request_bit && tx_q.full_power)
    else $error("no full power reply to sync");
  chk_low_power_done: assert property ( // R9
    state_q == swa_pkg::SWA_SYNC_WAIT && rx_frame.valid
    && rx_frame.kind == swa_pkg::SWA_RX_SYNC && lowpwr_q
    |=> state_q == swa_pkg::SWA_SUCCESS && !tx_q.valid)
    else $error("low power sync not accepted");
  chk_corrupt_repeat: assert property ( // R10
    state_q == swa_pkg::SWA_SYNC_WAIT && rx_frame.valid
    && rx_frame.kind == swa_pkg::SWA_RX_CORRUPT && rep_q == 2'h0
    |=> tx_q.valid && tx_q.repeat_request_bit && rep_q == 2'h1)
    else $error("corrupt frame without repeat");
  chk_resume_line_high: assert property ( // R23
    $rose(link_q) |-> $past(line_q) && $past(sc_s2_q) && $past(ln_s2_q))
    else $error("resume taken with line low");

  cov_full_power_ok: cover property (
    state_q == swa_pkg::SWA_RESP_WAIT ##1 state_q == swa_pkg::SWA_SUCCESS);
  cov_low_power_ok: cover property (
    state_q == swa_pkg::SWA_SYNC_WAIT ##1 state_q == swa_pkg::SWA_SUCCESS);
  cov_repeat_three: cover property (rep_q == 2'h3);
  cov_fail: cover property ($rose(fail_q));
endmodule
`default_nettype wire

// *** hdl/swa_defines.svh ***
// constants for the single wire activation controller
`ifndef SWA_DEFINES_SVH
`define SWA_DEFINES_SVH
`define SWA_CLK_MHZ 25
`define SWA_T_LINE_RAISE_US 1000
`define SWA_T_RES_SUPPLY_US 700
`define SWA_T_RES_DEACT_US 500
`define SWA_T_FRAME_REPLY_US 2000
`define SWA_MAX_REPEATS 2'h3
`define SWA_ADDR_W 12
`define SWA_OFF_CTRL 12'h000
`define SWA_OFF_STATUS 12'h004
`define SWA_CTRL_START 0
`define SWA_CTRL_STOP 1
`define SWA_CTRL_LOWPWR 2
`define SWA_CNT_W 17
`endif

// *** hdl/swa_pkg.sv ***
// types for the single wire activation controller
package swa_pkg;
  typedef enum logic [7:0] {
    SWA_IDLE = 8'h01,
    SWA_PWR_WAIT = 8'h02,
    SWA_RESUME_WAIT = 8'h04,
    SWA_SYNC_WAIT = 8'h08,
    SWA_RESP_WAIT = 8'h10,
    SWA_SUCCESS = 8'h20,
    SWA_FAIL = 8'h40,
    SWA_SHUTDOWN = 8'h80
  } swa_state_e;
  typedef enum logic [1:0] {
    SWA_RX_SYNC = 2'h0,
    SWA_RX_READY = 2'h1,
    SWA_RX_OTHER = 2'h2,
    SWA_RX_CORRUPT = 2'h3
  } swa_rx_kind_e;
  typedef struct packed {
    logic valid;
    swa_rx_kind_e kind;
  } swa_rx_s;
  typedef struct packed {
    logic valid;
    logic repeat_request_bit;
    logic full_power;
  } swa_tx_s;
endpackage

// *** dv/swa_card_model.sv ***
// card side model for the single wire activation link
`timescale 1ns/1ps
`default_nettype none
module swa_card_model (
  input wire logic sys_clk, // bench clock
  input wire logic supply_en, // card supply
  input wire logic master_voltage_signal, // line from front end
  input wire swa_pkg::swa_tx_s tx_frame, // power mode frame request
  output logic tx_ready, // frame accepted
  output logic slave_current_signal, // current drawn by card
  output swa_pkg::swa_rx_s rx_frame, // frame seen by front end
  input wire logic no_resume, // card never resumes
  input wire logic [2:0] fault_at, // first frame index to spoil
  input wire logic [2:0] fault_cnt, // number of spoiled frames
  input wire swa_pkg::swa_rx_kind_e fault_kind, // shown kind, sync = none
  input wire logic [4:0] resume_dly, // cycles before resume
  input wire logic [4:0] reply_dly, // cycles before answering
  input wire logic [1:0] rdy_dly // cycles before accepting
);
  logic drawing, fr;
  logic tog = 1'b0;
  logic [1:0] phase;
  logic [5:0] cnt;
  logic [3:0] idx;
  swa_pkg::swa_rx_kind_e last;
  // outside the high phase the current is junk the host must ignore
  assign slave_current_signal = master_voltage_signal ? drawing : tog;
  // send a frame, spoiled or dropped when the bench asks for it
  task automatic send(input swa_pkg::swa_rx_kind_e k);
    if (idx >= {1'b0, fault_at} && idx < {1'b0, fault_at} + fault_cnt) begin
      if (fault_kind != swa_pkg::SWA_RX_SYNC)
        rx_frame <= '{1'b1, fault_kind};
    end else
      rx_frame <= '{1'b1, k};
    idx <= idx + 4'h1;
  endtask
  // card sequencer; a low line or no supply puts it back to sleep
  always @(posedge sys_clk) begin
    tog <= ~tog;
    rx_frame <= '0;
    tx_ready <= 1'b0;
    cnt <= cnt + 6'h1;
    if (!supply_en || !master_voltage_signal) begin
      phase <= 2'h0;
      cnt <= 6'h0;
      idx <= 4'h0;
      drawing <= 1'b0;
      last <= swa_pkg::SWA_RX_SYNC;
    end else begin
      case (phase)
        2'h0: if (!no_resume && cnt >= {1'b0, resume_dly}) begin
          drawing <= 1'b1;
          phase <= 2'h1;
          cnt <= 6'h0;
        end
        2'h1: if (cnt == 6'h08) begin
          send(last);
          phase <= 2'h2;
          cnt <= 6'h0;
        end
        2'h2: if (tx_ready && tx_frame.valid) begin
          fr <= tx_frame.repeat_request_bit;
          phase <= 2'h3;
          cnt <= 6'h0;
        end else if (tx_frame.valid && cnt >= {4'h0, rdy_dly})
          tx_ready <= 1'b1;
        default: if (cnt >= {1'b0, reply_dly}) begin
          if (!fr)
            last <= swa_pkg::SWA_RX_READY;
          send(fr ? last : swa_pkg::SWA_RX_READY);
          phase <= 2'h2;
          cnt <= 6'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the single wire activation controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, supply_en, line, cur, tx_ready, link, er;
  swa_pkg::swa_rx_s rx;
  swa_pkg::swa_tx_s tx;
  logic nr = 1'b0;
  logic [2:0] fa = 3'h0;
  logic [2:0] fc = 3'h0;
  swa_pkg::swa_rx_kind_e fk = swa_pkg::SWA_RX_CORRUPT;
  logic [4:0] rs_d = 5'h1;
  logic [4:0] rp_d = 5'h1;
  logic [1:0] rd_d = 2'h0;
  logic [1:0] txq[$];
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h9da05a44;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // controller with short timing counts
  swa_host #(.LINE_RAISE_CYC(20), .RES_SUPPLY_CYC(15), .RES_DEACT_CYC(10),
    .REPLY_CYC(40)) dut_u (.sys_clk(sys_clk), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_en(supply_en), .master_voltage_signal(line),
    .slave_current_signal(cur), .rx_frame(rx), .tx_frame(tx),
    .tx_ready(tx_ready), .link_activated(link));
  // card on the far side
  swa_card_model card_u (.sys_clk(sys_clk), .supply_en(supply_en),
    .master_voltage_signal(line), .tx_frame(tx), .tx_ready(tx_ready),
    .slave_current_signal(cur), .rx_frame(rx), .no_resume(nr),
    .fault_at(fa), .fault_cnt(fc), .fault_kind(fk), .resume_dly(rs_d),
    .reply_dly(rp_d), .rdy_dly(rd_d));
  task automatic results();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // frame log, supply order watch and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!reset && tx.valid && tx_ready)
      txq.push_back({tx.repeat_request_bit, tx.full_power});
    if (!reset) check({31'h0, line & ~supply_en}, 32'h0);
    if (cyc == 30000) begin
      fails = fails + 1;
      results();
    end
  end
  // one activation attempt: expectations from power mode and faults
  task automatic run(input bit lp, input bit r, input int a, input int c,
    input swa_pkg::swa_rx_kind_e k);
    bit good, ok;
    int e, n, ntx;
    logic [15:0] st;
    good = (a != 0 || c == 0);
    e = (lp && good) ? 0 : c;
    ok = !r && e <= 3;
    ntx = r ? 0 : ((!lp && good) ? 1 : 0) + (e > 3 ? 3 : e);
    st = {(e > 3 ? 2'h3 : 2'(e)), ok, !ok, ok, ok, ok, 1'b1,
      (ok ? 8'h20 : 8'h40)};
    nr <= r;
    fa <= a[2:0];
    fc <= c[2:0];
    fk <= k;
    rs_d <= 5'(1 + {$random(seed)} % 12);
    rp_d <= 5'(1 + {$random(seed)} % 30);
    rd_d <= 2'($random(seed));
    txq.delete();
    apb(1'b1, 12'h000, {29'h0, lp, 2'h1}, rd, er);
    n = 0;
    while (!supply_en) @(posedge sys_clk);
    while (!line) begin
      @(posedge sys_clk);
      n++;
    end
    check({31'h0, n >= 20}, 32'h1);
    do apb(1'b0, 12'h004, 32'h0, rd, er);
    while (rd[7:0] !== 8'h20 && rd[7:0] !== 8'h40);
    check(rd, {16'h0, st});
    check({31'h0, link}, {31'h0, ok});
    check(32'(txq.size()), 32'(ntx));
    foreach (txq[i]) check({30'h0, txq[i]},
      {30'h0, ((i == 0 && !lp && good) ? 1'b0 : 1'b1), !lp});
    apb(1'b1, 12'h000, 32'h2, rd, er);
    do apb(1'b0, 12'h004, 32'h0, rd, er); while (rd[7:0] !== 8'h01);
    check(rd, {16'h0, st[15:14], 1'b0, st[12:11], 11'h001});
  endtask
  // reset, register checks, corner cases, then random attempts
  initial begin
    int r1;
    swa_pkg::swa_rx_kind_e k;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    check(rd, 32'h1);
    apb(1'b1, 12'h008, 32'h7, rd, er);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 12'h000, 32'h4, rd, er);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    check(rd & 32'h4, 32'h4);
    run(0, 0, 1, 0, swa_pkg::SWA_RX_CORRUPT);
    run(1, 0, 1, 0, swa_pkg::SWA_RX_CORRUPT);
    run(0, 0, 0, 1, swa_pkg::SWA_RX_CORRUPT);
    run(0, 0, 1, 2, swa_pkg::SWA_RX_OTHER);
    run(0, 0, 1, 1, swa_pkg::SWA_RX_SYNC);
    run(0, 0, 0, 3, swa_pkg::SWA_RX_CORRUPT);
    run(0, 0, 1, 4, swa_pkg::SWA_RX_CORRUPT);
    run(1, 0, 0, 4, swa_pkg::SWA_RX_OTHER);
    run(0, 1, 1, 0, swa_pkg::SWA_RX_CORRUPT);
    for (int i = 0; i < 6; i++) begin
      r1 = {$random(seed)};
      k = r1[6] ? swa_pkg::SWA_RX_CORRUPT : swa_pkg::SWA_RX_OTHER;
      if (r1[1] && r1[5])
        k = swa_pkg::SWA_RX_SYNC;
      run(r1[0], 1'b0, int'(r1[1]), int'(r1[4:2] % 5), k);
    end
    results();
  end
endmodule
`default_nettype wire
